// ### cmpe_core_model.sv
`timescale 1ns/1ns
module cmpe_core_model (
    // reference routing from the block
    input  wire logic [1:0] refSrcSel,
    input  wire logic       refEnable,
    // input voltage relation set by the bench
    input  wire logic       testAbove,
    // raw comparator result
    output logic            cmpOutAsync
);
    // internal reference switched off: no valid compare, output held low
    always_comb
        cmpOutAsync = (refSrcSel == 2'h2 && !refEnable) ? 1'b0 : testAbove;
endmodule // cmpe_core_model

// ### cmpe_pkg.sv
package cmpe_pkg;

    // trigger / interrupt condition encodings
    typedef enum logic [2:0] {
        trig_off       = 3'h0,
        trig_level_hi  = 3'h1,
        trig_level_lo  = 3'h3,
        trig_edge_down = 3'h2,
        trig_edge_up   = 3'h6,
        trig_edge_any  = 3'h7
    } cmpe_cond_t;

    typedef enum logic [1:0] {
        ref_src_own_pin   = 2'h0,
        ref_src_first_pin = 2'h1,
        ref_src_internal  = 2'h2
    } cmpe_src_t;

    // register byte offsets
    localparam logic [11:0] OFF_CFG    = 12'h000;
    localparam logic [11:0] OFF_REF    = 12'h004;
    localparam logic [11:0] OFF_IEN    = 12'h008;
    localparam logic [11:0] OFF_RAW    = 12'h00c;
    localparam logic [11:0] OFF_MIS    = 12'h010;
    localparam logic [11:0] OFF_VAL    = 12'h014;
    localparam logic [11:0] OFF_EVT    = 12'h018;
    localparam logic [11:0] OFF_EVTMSK = 12'h01c;

    // config field positions
    localparam int CFG_TRIG_LSB = 0;
    localparam int CFG_INT_LSB  = 4;
    localparam int CFG_SRC_LSB  = 8;
    localparam int CFG_INV_BIT  = 12;

    localparam int          REF_W     = 5;
    localparam logic [4:0]  REF_OFF   = 5'h1f;
    localparam logic [4:0]  REF_TOP   = 5'h1c;
    localparam int          EVT_W     = 3;

    typedef struct packed {
        logic       invert;
        cmpe_src_t  src;
        cmpe_cond_t intCond;
        cmpe_cond_t trigCond;
    } cmpe_cfg_t;

    localparam cmpe_cfg_t CFG_RESET = '{invert: 1'b0, src: ref_src_own_pin,
                                        intCond: trig_off, trigCond: trig_off};

endpackage

// ### cmpe_sync.sv
`timescale 1ns/1ns
module cmpe_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // async in / synced out
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1Reg;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stage1Reg <= 1'b0;
            syncOut   <= 1'b0;
        end else begin
            stage1Reg <= asyncIn;
            syncOut   <= stage1Reg;
        end
    end
endmodule // cmpe_sync

// ### cmpe_top.sv
// Behaviour
// - trigger select has an off setting and level-high and level-low settings.
// - trigger select has falling, rising and either-edge settings.
// - interrupt select has level-high and level-low settings.
// - interrupt select has falling, rising and either-edge settings.
// - interrupt and trigger conditions are decoded independently.
// - reference source picks own pin, comparator zero pin or internal reference.
// - output pin carries the result plain or inverted.
// - a software clear drops the pending interrupt.
// - with a level condition the pending bit stays set while the level holds.
// - the pending interrupt reaches the processor only while enabled.
// - software reads both raw and enable-gated pending state.
// - reference level select has an off code and steps from 0 V upward.
// - software reads the live comparator output as one or zero.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module cmpe_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog side
    input  wire logic        cmpOutAsync,
    output logic      [1:0]  refSrcSel,
    output logic      [4:0]  refLevelSel,
    output logic             refEnable,
    // converter and pin
    output logic             adcTrig,
    output logic             cmpPinOut,
    // interrupt
    output logic             irq
);
    cmpe_pkg::cmpe_cfg_t cfg_reg;
    logic [cmpe_pkg::REF_W-1:0] ref_reg;
    logic                       ien_reg;
    logic                       pend_reg;
    logic [cmpe_pkg::EVT_W-1:0] evt_reg;
    logic [cmpe_pkg::EVT_W-1:0] evtMsk_reg;
    logic                       cmpSync;
    logic                       cmpPrev_reg;
    logic                       intHit;
    logic                       trigHit;
    logic                       wrEn;
    logic                       rdEn;
    logic                       clrPend;
    logic                       rdEvt;
    logic [cmpe_pkg::EVT_W-1:0] evtSet;
    logic [31:0]                rdData;
    logic                       addrOk;

    // condition decode, used for both trigger and interrupt
    function automatic logic condHit(input cmpe_pkg::cmpe_cond_t c,
                                     input logic cur, input logic prev);
        case (c)
            cmpe_pkg::trig_off:       condHit = 1'b0;
            cmpe_pkg::trig_level_hi:  condHit = cur;
            cmpe_pkg::trig_level_lo:  condHit = !cur;
            cmpe_pkg::trig_edge_down: condHit = prev && !cur;
            cmpe_pkg::trig_edge_up:   condHit = !prev && cur;
            cmpe_pkg::trig_edge_any:  condHit = prev ^ cur;
            default:                  condHit = 1'b0;
        endcase
    endfunction

    function automatic logic isLevel(input cmpe_pkg::cmpe_cond_t c);
        isLevel = (c == cmpe_pkg::trig_level_hi) || (c == cmpe_pkg::trig_level_lo);
    endfunction

    cmpe_sync u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .asyncIn (cmpOutAsync),
        .syncOut (cmpSync)
    );

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cmpPrev_reg <= 1'b0;
        end else begin
            cmpPrev_reg <= cmpSync;
        end
    end

    // independent decoders
    assign trigHit = condHit(cfg_reg.trigCond, cmpSync, cmpPrev_reg);
    assign intHit  = condHit(cfg_reg.intCond, cmpSync, cmpPrev_reg);

    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && penable && !pwrite;
    assign clrPend = wrEn && (paddr == cmpe_pkg::OFF_RAW) && pwdata[0];
    assign rdEvt   = rdEn && (paddr == cmpe_pkg::OFF_EVT);
    assign evtSet  = {trigHit, cmpSync != cmpPrev_reg, intHit};

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_reg    <= cmpe_pkg::CFG_RESET;
            ref_reg    <= cmpe_pkg::REF_OFF;
            ien_reg    <= 1'b0;
            evtMsk_reg <= '0;
        end else if (wrEn) begin
            case (paddr)
                cmpe_pkg::OFF_CFG: begin
                    cfg_reg.trigCond <= cmpe_pkg::cmpe_cond_t'(
                        pwdata[cmpe_pkg::CFG_TRIG_LSB +: 3]);
                    cfg_reg.intCond  <= cmpe_pkg::cmpe_cond_t'(
                        pwdata[cmpe_pkg::CFG_INT_LSB +: 3]);
                    cfg_reg.src      <= cmpe_pkg::cmpe_src_t'(
                        pwdata[cmpe_pkg::CFG_SRC_LSB +: 2]);
                    cfg_reg.invert   <= pwdata[cmpe_pkg::CFG_INV_BIT];
                end
                cmpe_pkg::OFF_REF:    ref_reg    <= pwdata[cmpe_pkg::REF_W-1:0];
                cmpe_pkg::OFF_IEN:    ien_reg    <= pwdata[0];
                cmpe_pkg::OFF_EVTMSK: evtMsk_reg <= pwdata[cmpe_pkg::EVT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // pending interrupt: set wins over clear, level holds it set
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pend_reg <= 1'b0;
        end else if (intHit) begin
            pend_reg <= 1'b1;
        end else if (clrPend) begin
            pend_reg <= 1'b0;
        end
    end

    // sticky event status, cleared by read, set wins
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            evt_reg <= '0;
        end else begin
            evt_reg <= (rdEvt ? '0 : evt_reg) | evtSet;
        end
    end

    // read mux
    always_comb begin
        addrOk = 1'b1;
        rdData = '0;
        case (paddr)
            cmpe_pkg::OFF_CFG: begin
                rdData[cmpe_pkg::CFG_TRIG_LSB +: 3] = cfg_reg.trigCond;
                rdData[cmpe_pkg::CFG_INT_LSB +: 3]  = cfg_reg.intCond;
                rdData[cmpe_pkg::CFG_SRC_LSB +: 2]  = cfg_reg.src;
                rdData[cmpe_pkg::CFG_INV_BIT]       = cfg_reg.invert;
            end
            cmpe_pkg::OFF_REF:    rdData[cmpe_pkg::REF_W-1:0] = ref_reg;
            cmpe_pkg::OFF_IEN:    rdData[0] = ien_reg;
            cmpe_pkg::OFF_RAW:    rdData[0] = pend_reg;
            cmpe_pkg::OFF_MIS:    rdData[0] = pend_reg && ien_reg;
            cmpe_pkg::OFF_VAL:    rdData[0] = cmpSync;
            cmpe_pkg::OFF_EVT:    rdData[cmpe_pkg::EVT_W-1:0] = evt_reg;
            cmpe_pkg::OFF_EVTMSK: rdData[cmpe_pkg::EVT_W-1:0] = evtMsk_reg;
            default:              addrOk = 1'b0;
        endcase
    end

    // apb answer: no wait states, data registered
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            prdata  <= (psel && !penable && !pwrite) ? rdData : '0;
            pslverr <= psel && !penable && !addrOk;
        end
    end

    // outputs from flops
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            adcTrig     <= 1'b0;
            cmpPinOut   <= 1'b0;
            irq         <= 1'b0;
            refSrcSel   <= cmpe_pkg::ref_src_own_pin;
            refLevelSel <= cmpe_pkg::REF_OFF;
            refEnable   <= 1'b0;
        end else begin
            adcTrig     <= trigHit;
            cmpPinOut   <= cmpSync ^ cfg_reg.invert;
            irq         <= (pend_reg && ien_reg) || |(evt_reg & evtMsk_reg);
            refSrcSel   <= cfg_reg.src;
            refLevelSel <= ref_reg;
            refEnable   <= ref_reg <= cmpe_pkg::REF_TOP;
        end
    end

    a_irq_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !ien_reg && !(|(evt_reg & evtMsk_reg)) |=> !irq)
        else $error("irq raised while disabled");
    a_pend_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        isLevel(cfg_reg.intCond) && intHit |=> pend_reg)
        else $error("level pending lost");
    a_pend_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clrPend && !intHit |=> !pend_reg)
        else $error("pending not cleared");
    a_trig_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_reg.trigCond == cmpe_pkg::trig_edge_up && $rose(cmpSync) |=> adcTrig)
        else $error("rising trigger missed");
    a_trig_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_reg.trigCond == cmpe_pkg::trig_off |=> !adcTrig)
        else $error("trigger while off");
    a_pin_invert: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##1 cmpPinOut == ($past(cmpSync) ^ $past(cfg_reg.invert)))
        else $error("pin polarity wrong");
    a_int_fall: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cfg_reg.intCond == cmpe_pkg::trig_edge_down && $fell(cmpSync) |=> pend_reg)
        else $error("falling interrupt missed");
    a_sync_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ##2 cmpSync == $past(cmpOutAsync, 2))
        else $error("sync delay wrong");
endmodule // cmpe_top

// ### comparator_event_logic_tb.sv
`timescale 1ns/1ns
module comparator_event_logic_tb;
    logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, testAbove = 1'b0, trigPrev = 1'b0;
    logic        pready, pslverr, cmpOutAsync, adcTrig, cmpPinOut, irq, refEnable, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  refSrcSel;
    logic [4:0]  refLevelSel;
    logic [4:0]  lvls [3] = '{5'h00, 5'h1c, 5'h1f};
    int          n_errors = 0, check_count = 0, trigEdges = 0, base;
    // code; after rise: edges, level, raw; after fall: edges, level, raw
    logic [8:0]  rows [6] = '{{cmpe_pkg::trig_off, 6'b000000},
        {cmpe_pkg::trig_level_hi, 6'b111001}, {cmpe_pkg::trig_level_lo, 6'b001111},
        {cmpe_pkg::trig_edge_down, 6'b000101}, {cmpe_pkg::trig_edge_up, 6'b101000},
        {cmpe_pkg::trig_edge_any, 6'b101101}};

    always #50 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        trigPrev <= adcTrig;
        if (adcTrig && !trigPrev) trigEdges <= trigEdges + 1;
    end

    cmpe_top DUT (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                  .pready, .pslverr, .cmpOutAsync, .refSrcSel, .refLevelSel, .refEnable,
                  .adcTrig, .cmpPinOut, .irq);
    cmpe_core_model core (.refSrcSel, .refEnable, .testAbove, .cmpOutAsync);

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    function automatic logic [31:0] cw(input logic [2:0] t, i, input logic [1:0] s,
                                       input logic v);
        return {19'h0, v, 2'h0, s, 1'b0, i, 1'b0, t};
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end

    initial begin
        step(8);
        reset_n <= 1'b1;
        step(1);
        chk(refLevelSel, 32'h1f);
        chk({refEnable, adcTrig, irq, cmpPinOut}, 32'h0);
        for (int r = 0; r < 6; r++) begin
            apb(1'b1, cmpe_pkg::OFF_CFG, cw(rows[r][8:6], rows[r][8:6], 2'h0, 1'b0));
            step(6);
            apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
            base = trigEdges;
            testAbove <= 1'b1;
            step(6);
            chk(trigEdges - base, rows[r][5]);
            chk(adcTrig, rows[r][4]);
            apb(1'b0, cmpe_pkg::OFF_RAW, 32'h0);
            chk(rd[0], rows[r][3]);
            apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
            base = trigEdges;
            testAbove <= 1'b0;
            step(6);
            chk(trigEdges - base, rows[r][2]);
            chk(adcTrig, rows[r][1]);
            apb(1'b0, cmpe_pkg::OFF_RAW, 32'h0);
            chk(rd[0], rows[r][0]);
            $display("test condition row %0d done", r);
        end
        // trigger on falling, interrupt on rising
        apb(1'b1, cmpe_pkg::OFF_CFG, cw(cmpe_pkg::trig_edge_down, cmpe_pkg::trig_edge_up,
                                       2'h0, 1'b0));
        apb(1'b1, cmpe_pkg::OFF_IEN, 32'h1);
        apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
        base = trigEdges;
        testAbove <= 1'b1;
        step(6);
        chk(trigEdges - base, 32'h0);
        chk(irq, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_MIS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
        step(2);
        chk(irq, 32'h0);
        apb(1'b1, cmpe_pkg::OFF_IEN, 32'h0);
        testAbove <= 1'b0;
        step(6);
        testAbove <= 1'b1;
        step(6);
        chk(irq, 32'h0);
        apb(1'b0, cmpe_pkg::OFF_RAW, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_MIS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, cmpe_pkg::OFF_CFG, cw(cmpe_pkg::trig_off, cmpe_pkg::trig_level_hi,
                                       2'h0, 1'b0));
        apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_RAW, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_VAL, 32'h0);
        chk(rd, 32'h1);
        testAbove <= 1'b0;
        step(6);
        apb(1'b1, cmpe_pkg::OFF_RAW, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_RAW, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, cmpe_pkg::OFF_VAL, 32'h0);
        chk(rd, 32'h0);
        $display("test interrupt done");
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, cmpe_pkg::OFF_CFG, cw(3'h0, 3'h0, s[1:0], s[0]));
            step(2);
            chk(refSrcSel, s);
            chk(cmpPinOut, s[0]);
        end
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, cmpe_pkg::OFF_REF, {27'h0, lvls[k]});
            step(2);
            chk(refLevelSel, lvls[k]);
            chk(refEnable, k < 2);
        end
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, cmpe_pkg::OFF_EVT, 32'h0);
        apb(1'b0, cmpe_pkg::OFF_EVT, 32'h0);
        chk(rd, 32'h0);
        // any-edge event through its mask to irq, cleared by read
        apb(1'b1, cmpe_pkg::OFF_CFG, 32'h0);
        apb(1'b1, cmpe_pkg::OFF_EVTMSK, 32'h2);
        testAbove <= 1'b1;
        step(6);
        chk(irq, 32'h1);
        apb(1'b0, cmpe_pkg::OFF_EVT, 32'h0);
        chk(rd, 32'h2);
        step(2);
        chk(irq, 32'h0);
        $display("test routing done");
        final_report();
    end
endmodule // comparator_event_logic_tb
